// file: core/ppb_core.sv
// program counter paging and data bank decode
//
// Notes on behaviour
// - twelve-bit program counter addresses 4096 words of 13 bits
// - any reset loads the counter with all ones
// - hardware interrupt sends fetch to 008h
// - software interrupt instruction sends fetch to 002h
// - ordinary call and jump carry a 10-bit in-page target
// - upper two counter bits come from latch bits 3 and 2
// - return restores all twelve bits from the stack
// - page instruction updates the page bits for later branches
// - far call and far jump reach all 4K directly
// - pointer bits 7 and 6 select one of four data banks
// - bank instruction updates the pointer bank bits
// - bank 0 holds special registers 00h-0Fh, storage from 10h
// - 00h-1Fh shared across banks, 20h-3Fh separate per bank
// - storage reached directly or through the pointer
// - option register has no address, written by its instruction only
// - direction instruction writes direction register 05h, 06h or 07h
`timescale 1ns/1ns
module ppb_core
    import ppb_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire ppb_cmd_t     cmd,
    input  wire logic [11:0]  stack_top,
    input  wire ppb_dacc_t    dacc,
    output logic [11:0]       fetch_addr,
    output logic [11:0]       push_addr,
    output logic              push_en,
    output logic [1:0]        bank_sel,
    output logic [7:0]        rdata,
    output logic              sfr_hit,
    output logic [5:0]        sfr_addr,
    output ppb_wo_regs_t      wo_regs
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [11:0] paged(input logic [7:0] pch, input logic [11:0] t);
        paged = {pch[PCH_HIGH_MSB:PCH_PAGE_LSB], t[PAGE_OFS_W-1:0]};
    endfunction : paged

    function automatic logic is_shared(input logic [5:0] a);
        is_shared = (a < GPR_BANKED_LO);
    endfunction : is_shared

    // ------------------------------------------------------------
    // program counter state
    // ------------------------------------------------------------
    logic [11:0] pc_q, pc_d;
    logic [11:0] push_q, push_d;
    logic        push_en_q, push_en_d;
    logic [7:0]  pch_q, pch_d;
    logic [7:0]  fsr_q, fsr_d;

    // effective data address and bank
    logic [5:0]  eff_addr;
    logic [1:0]  eff_bank;
    logic        gpr_hit;
    logic [7:0]  gpr_rdata;
    logic [7:0]  gpr_idx;

    always_comb
    begin
        // indirect goes through the pointer's low bits and its own bank
        eff_addr = dacc.indirect ? fsr_q[5:0] : dacc.addr;
        eff_bank = fsr_q[7:FSR_BANK_LSB];
        gpr_hit  = (eff_addr >= GPR_SHARED_LO);
        if (is_shared(eff_addr))
        begin
            gpr_idx = {4'h0, eff_addr[3:0]};
        end
        else
        begin
            gpr_idx = 8'(SHARED_GPR_N) + {1'b0, eff_bank, eff_addr[4:0]};
        end
    end

    // ------------------------------------------------------------
    // counter, latch and pointer next state
    // ------------------------------------------------------------
    always_comb
    begin
        pc_d      = pc_q + 12'h001;
        push_d    = push_q;
        push_en_d = 1'b0;
        pch_d     = pch_q;
        fsr_d     = fsr_q;
        case (cmd.op)
            PPB_OP_NONE:  pc_d = pc_q;
            PPB_OP_NEXT:  pc_d = pc_q + 12'h001;
            PPB_OP_JUMP:  pc_d = paged(pch_q, cmd.target);
            PPB_OP_CALL:
            begin
                pc_d      = paged(pch_q, cmd.target);
                push_d    = pc_q + 12'h001;
                push_en_d = 1'b1;
            end
            PPB_OP_FJUMP: pc_d = cmd.target;
            PPB_OP_FAR_CALL_INSTR:
            begin
                pc_d      = cmd.target;
                push_d    = pc_q + 12'h001;
                push_en_d = 1'b1;
            end
            PPB_OP_RET:   pc_d = stack_top;
            PPB_OP_HWIRQ:
            begin
                pc_d      = PC_HW_IRQ_VEC;
                push_d    = pc_q;
                push_en_d = 1'b1;
            end
            PPB_OP_SWIRQ:
            begin
                pc_d      = PC_SW_IRQ_VEC;
                push_d    = pc_q + 12'h001;
                push_en_d = 1'b1;
            end
            PPB_OP_PAGE:  pch_d[PCH_HIGH_MSB:PCH_PAGE_LSB] = cmd.operand[1:0];
            PPB_OP_BANK:  fsr_d[7:FSR_BANK_LSB] = cmd.operand[1:0];
            default:      pc_d = pc_q + 12'h001;
        endcase
        // data writes to the counter low byte, latch and pointer
        if (dacc.wr && !gpr_hit)
        begin
            case (eff_addr)
                ADDR_PCL:    pc_d  = {pch_q[PCH_HIGH_MSB:0], dacc.wdata};
                ADDR_PC_HIGH_LATCH: pch_d = {4'h0, dacc.wdata[3:0]};
                ADDR_FSR:    fsr_d = dacc.wdata;
                default:     fsr_d = fsr_d;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            pc_q      <= PC_RESET_VEC;
            push_q    <= 12'h000;
            push_en_q <= 1'b0;
            pch_q     <= PCH_RESET;
            fsr_q     <= FSR_RESET;
        end
        else
        begin
            pc_q      <= pc_d;
            push_q    <= push_d;
            push_en_q <= push_en_d;
            pch_q     <= pch_d;
            fsr_q     <= fsr_d;
        end
    end

    // ------------------------------------------------------------
    // storage and read path
    // ------------------------------------------------------------
    logic [7:0] rdata_q, rdata_d;
    logic       sfr_hit_q, sfr_hit_d;
    logic [5:0] sfr_addr_q, sfr_addr_d;

    ppb_gpr_store u_gpr (
        .clk   (clk),
        .nrst  (nrst),
        .we    (dacc.wr && gpr_hit),
        .idx   (gpr_idx),
        .wdata (dacc.wdata),
        .rdata (gpr_rdata)
    );

    always_comb
    begin
        rdata_d    = 8'h00;
        sfr_hit_d  = 1'b0;
        sfr_addr_d = eff_addr;
        if (dacc.rd || dacc.wr)
        begin
            if (gpr_hit)
            begin
                rdata_d = gpr_rdata;
            end
            else
            begin
                // other special registers live outside this block
                sfr_hit_d = 1'b1;
                case (eff_addr)
                    ADDR_PCL:    rdata_d = pc_q[7:0];
                    ADDR_FSR:    rdata_d = fsr_q;
                    ADDR_PC_HIGH_LATCH: rdata_d = {4'h0, pch_q[3:0]};
                    default:     rdata_d = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            rdata_q    <= 8'h00;
            sfr_hit_q  <= 1'b0;
            sfr_addr_q <= 6'h00;
        end
        else
        begin
            rdata_q    <= rdata_d;
            sfr_hit_q  <= sfr_hit_d;
            sfr_addr_q <= sfr_addr_d;
        end
    end

    // ------------------------------------------------------------
    // write-only registers
    // ------------------------------------------------------------
    ppb_wo_regs u_wo (
        .clk    (clk),
        .nrst   (nrst),
        .opt_we (cmd.op == PPB_OP_OPT),
        .dir_we (cmd.op == PPB_OP_DIR),
        .sel    (cmd.operand),
        .wdata  (dacc.wdata),
        .regs_q (wo_regs)
    );

    assign fetch_addr = pc_q;
    assign push_addr  = push_q;
    assign push_en    = push_en_q;
    assign bank_sel   = fsr_q[7:FSR_BANK_LSB];
    assign rdata      = rdata_q;
    assign sfr_hit    = sfr_hit_q;
    assign sfr_addr   = sfr_addr_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_reset_vec;
        @(posedge clk) !nrst |=> fetch_addr == PC_RESET_VEC;
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("reset vector wrong");

    property p_hw_irq;
        @(posedge clk) disable iff (!nrst)
        cmd.op == PPB_OP_HWIRQ && !dacc.wr |=> fetch_addr == 12'h008 && push_en;
    endproperty
    a_hw_irq: assert property (p_hw_irq) else $error("hw irq vector wrong");

    property p_sw_irq;
        @(posedge clk) disable iff (!nrst)
        cmd.op == PPB_OP_SWIRQ && !dacc.wr |=> fetch_addr == 12'h002;
    endproperty
    a_sw_irq: assert property (p_sw_irq) else $error("sw irq vector wrong");

    property p_paged_jump;
        @(posedge clk) disable iff (!nrst)
        cmd.op == PPB_OP_JUMP && !dacc.wr
        |=> fetch_addr == {$past(pch_q[3:2]), $past(cmd.target[9:0])};
    endproperty
    a_paged_jump: assert property (p_paged_jump) else $error("paged jump wrong");

    property p_far_jump;
        @(posedge clk) disable iff (!nrst)
        cmd.op == PPB_OP_FJUMP && !dacc.wr |=> fetch_addr == $past(cmd.target);
    endproperty
    a_far_jump: assert property (p_far_jump) else $error("far jump wrong");

    property p_ret;
        @(posedge clk) disable iff (!nrst)
        cmd.op == PPB_OP_RET && !dacc.wr |=> fetch_addr == $past(stack_top);
    endproperty
    a_ret: assert property (p_ret) else $error("return address wrong");

    property p_next;
        @(posedge clk) disable iff (!nrst)
        cmd.op == PPB_OP_NEXT && !dacc.wr |=> fetch_addr == $past(fetch_addr) + 12'h001;
    endproperty
    a_next: assert property (p_next) else $error("increment wrong");

    property p_bank;
        @(posedge clk) disable iff (!nrst)
        cmd.op == PPB_OP_BANK && !dacc.wr |=> bank_sel == $past(cmd.operand[1:0]);
    endproperty
    a_bank: assert property (p_bank) else $error("bank select wrong");

    property p_page_then_jump;
        @(posedge clk) disable iff (!nrst)
        cmd.op == PPB_OP_PAGE && !dacc.wr ##1 cmd.op == PPB_OP_JUMP && !dacc.wr
        |=> fetch_addr[11:10] == $past(cmd.operand[1:0], 2);
    endproperty
    a_page_then_jump: assert property (p_page_then_jump) else $error("page unused");

    property p_dir_a;
        @(posedge clk) disable iff (!nrst)
        cmd.op == PPB_OP_DIR && cmd.operand == 8'h05 |=> wo_regs.dir_a == $past(dacc.wdata);
    endproperty
    a_dir_a: assert property (p_dir_a) else $error("direction a wrong");

    property p_dir_b;
        @(posedge clk) disable iff (!nrst)
        cmd.op == PPB_OP_DIR && cmd.operand == 8'h06 |=> wo_regs.dir_b == $past(dacc.wdata);
    endproperty
    a_dir_b: assert property (p_dir_b) else $error("direction b wrong");

    property p_dir_c;
        @(posedge clk) disable iff (!nrst)
        cmd.op == PPB_OP_DIR && cmd.operand == 8'h07 |=> wo_regs.dir_c == $past(dacc.wdata);
    endproperty
    a_dir_c: assert property (p_dir_c) else $error("direction c wrong");

    property p_opt;
        @(posedge clk) disable iff (!nrst)
        cmd.op == PPB_OP_OPT |=> wo_regs.opt == $past(dacc.wdata);
    endproperty
    a_opt: assert property (p_opt) else $error("option wrong");

    property p_call_push;
        @(posedge clk) disable iff (!nrst)
        cmd.op == PPB_OP_CALL && !dacc.wr |=> push_en && push_addr == $past(fetch_addr) + 12'h001;
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push wrong");

    property p_far_call_instr;
        @(posedge clk) disable iff (!nrst)
        cmd.op == PPB_OP_FAR_CALL_INSTR && !dacc.wr |=> fetch_addr == $past(cmd.target) && push_en;
    endproperty
    a_far_call_instr: assert property (p_far_call_instr) else $error("far call wrong");

    property p_sfr;
        @(posedge clk) disable iff (!nrst)
        (dacc.rd || dacc.wr) && !dacc.indirect && dacc.addr <= SFR_LAST |=> sfr_hit;
    endproperty
    a_sfr: assert property (p_sfr) else $error("special register hit wrong");

    c_call:  cover property (@(posedge clk) disable iff (!nrst) cmd.op == PPB_OP_CALL);
    c_ret:   cover property (@(posedge clk) disable iff (!nrst) cmd.op == PPB_OP_RET);
    c_bank3: cover property (@(posedge clk) disable iff (!nrst) bank_sel == 2'b11 && dacc.wr);
    c_irq:   cover property (@(posedge clk) disable iff (!nrst) cmd.op == PPB_OP_HWIRQ);
    c_far_call_instr: cover property (@(posedge clk) disable iff (!nrst) cmd.op == PPB_OP_FAR_CALL_INSTR);
endmodule : ppb_core

// file: core/ppb_pkg.sv
// package: constants and types for program paging and bank decode
package ppb_pkg;

    // ------------------------------------------------------------
    // program counter
    // ------------------------------------------------------------
    localparam int          PC_W          = 12;
    localparam int          PAGE_OFS_W    = 10;
    localparam int          INSTR_W       = 13;
    localparam logic [11:0] PC_RESET_VEC  = 12'hfff;
    localparam logic [11:0] PC_HW_IRQ_VEC = 12'h008;
    localparam logic [11:0] PC_SW_IRQ_VEC = 12'h002;
    localparam int          PCH_PAGE_LSB  = 2;
    localparam int          PCH_HIGH_MSB  = 3;

    // ------------------------------------------------------------
    // data memory map
    // ------------------------------------------------------------
    localparam int          DADDR_W       = 6;
    localparam int          FSR_BANK_LSB  = 6;
    localparam int          NUM_BANKS     = 4;
    localparam logic [5:0]  SFR_LAST      = 6'h0f;
    localparam logic [5:0]  GPR_SHARED_LO = 6'h10;
    localparam logic [5:0]  GPR_BANKED_LO = 6'h20;
    localparam int          SHARED_GPR_N  = 16;
    localparam int          BANKED_GPR_N  = 32;

    localparam logic [5:0]  ADDR_INDIRECT = 6'h00;
    localparam logic [5:0]  ADDR_PCL      = 6'h02;
    localparam logic [5:0]  ADDR_FSR      = 6'h04;
    localparam logic [5:0]  ADDR_PC_HIGH_LATCH   = 6'h0a;
    localparam logic [5:0]  ADDR_DIR_A    = 6'h05;
    localparam logic [5:0]  ADDR_DIR_B    = 6'h06;
    localparam logic [5:0]  ADDR_DIR_C    = 6'h07;

    localparam logic [7:0]  FSR_RESET     = 8'h00;
    localparam logic [7:0]  PCH_RESET     = 8'h00;
    localparam logic [7:0]  OPT_RESET     = 8'hff;
    localparam logic [7:0]  DIR_RESET     = 8'hff;

    // timer option register field positions
    localparam int          OPT_EDGE_BIT  = 6;
    localparam int          OPT_TCS_BIT   = 5;
    localparam int          OPT_TSE_BIT   = 4;
    localparam int          OPT_PSA_BIT   = 3;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        PPB_OP_NONE  = 4'b0000,
        PPB_OP_NEXT  = 4'b0001,
        PPB_OP_JUMP  = 4'b0010,
        PPB_OP_CALL  = 4'b0011,
        PPB_OP_FJUMP = 4'b0100,
        PPB_OP_FAR_CALL_INSTR = 4'b0101,
        PPB_OP_RET   = 4'b0110,
        PPB_OP_HWIRQ = 4'b0111,
        PPB_OP_SWIRQ = 4'b1000,
        PPB_OP_PAGE  = 4'b1001,
        PPB_OP_BANK  = 4'b1010,
        PPB_OP_OPT   = 4'b1011,
        PPB_OP_DIR   = 4'b1100
    } ppb_op_t;

    typedef struct packed {
        ppb_op_t     op;
        logic [11:0] target;
        logic [7:0]  operand;
    } ppb_cmd_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        indirect;
        logic [5:0]  addr;
        logic [7:0]  wdata;
    } ppb_dacc_t;

    typedef struct packed {
        logic [7:0]  opt;
        logic [7:0]  dir_a;
        logic [7:0]  dir_b;
        logic [7:0]  dir_c;
    } ppb_wo_regs_t;

endpackage : ppb_pkg

// file: core/ppb_wo_regs.sv
// write-only option and direction registers
`timescale 1ns/1ns
module ppb_wo_regs
    import ppb_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         opt_we,
    input  wire logic         dir_we,
    input  wire logic [7:0]   sel,
    input  wire logic [7:0]   wdata,
    output ppb_wo_regs_t      regs_q
);
    ppb_wo_regs_t regs_d;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        regs_d = regs_q;
        if (opt_we)
        begin
            regs_d.opt = wdata;
        end
        if (dir_we && sel[7:6] == 2'h0)
        begin
            case (sel[5:0])
                ADDR_DIR_A: regs_d.dir_a = wdata;
                ADDR_DIR_B: regs_d.dir_b = wdata;
                ADDR_DIR_C: regs_d.dir_c = wdata;
                default:    regs_d = regs_q;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            regs_q <= '{opt: OPT_RESET, dir_a: DIR_RESET, dir_b: DIR_RESET,
                        dir_c: DIR_RESET};
        end
        else
        begin
            regs_q <= regs_d;
        end
    end
endmodule : ppb_wo_regs

// file: core/ppb_gpr_store.sv
// general-purpose storage, shared and banked, as flip-flops
`timescale 1ns/1ns
module ppb_gpr_store
    import ppb_pkg::*;
#(
    parameter int DEPTH = SHARED_GPR_N + NUM_BANKS * BANKED_GPR_N
)
(
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] idx,
    input  wire logic [7:0]               wdata,
    output logic      [7:0]               rdata
);
    logic [7:0] mem_q [DEPTH];
    logic [7:0] mem_d [DEPTH];

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    always_comb
    begin
        mem_d = mem_q;
        if (we)
        begin
            mem_d[idx] = wdata;
        end
        rdata = mem_q[idx];
    end

    // contents are undefined by nature; cleared anyway to keep sim clean
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            mem_q[i] <= nrst ? mem_d[i] : 8'h00;
        end
    end
endmodule : ppb_gpr_store

// file: testbench/ppb_stack_model.sv
// behavioural return stack of the processor core side
`timescale 1ns/1ns
module ppb_stack_model
    import ppb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        push_en,
    input  wire logic [11:0] push_addr,
    input  wire logic        pop,
    output logic      [11:0] stack_top
);
    logic [11:0] mem [$];

    initial stack_top = 12'h000;

    // push lands one edge after the call, so a return needs one cycle of spacing
    always @(posedge clk)
    begin
        if (!nrst)
            mem.delete();
        else
        begin
            if (pop && mem.size() > 0)
                void'(mem.pop_back());
            if (push_en)
                mem.push_back(push_addr);
        end
        // empty stack inverts its last value each edge, so the stale address shows again every other cycle
        stack_top <= (mem.size() > 0) ? mem[$] : ~stack_top;
    end
endmodule : ppb_stack_model

// file: testbench/tb.sv
// self-checking bench for program paging and data bank decode
`timescale 1ns/1ns
module tb;
    import ppb_pkg::*;
    typedef struct { int cyc; int kind; logic [31:0] exp; } ppb_note_t;

    logic         clk;
    logic         nrst;
    ppb_cmd_t     cmd;
    ppb_dacc_t    dacc;
    logic [11:0]  stack_top;
    logic [11:0]  fetch_addr;
    logic [11:0]  push_addr;
    logic         push_en;
    logic [1:0]   bank_sel;
    logic [7:0]   rdata;
    logic         sfr_hit;
    logic [5:0]   sfr_addr;
    ppb_wo_regs_t wo_regs;
    ppb_note_t    notes [$];
    ppb_note_t    nt;
    int           cyc;
    int           bad_count;
    int           checked;
    logic [31:0]  rng;
    logic [11:0]  m_pc;
    logic [7:0]   m_pch;
    logic [7:0]   m_fsr;
    logic [11:0]  m_stk [$];
    ppb_wo_regs_t m_wo;
    logic [7:0]   m_mem [0:143];
    ppb_op_t      rops [5] = '{PPB_OP_NEXT, PPB_OP_JUMP, PPB_OP_FJUMP, PPB_OP_PAGE, PPB_OP_BANK};

    ppb_core i_ppb_core (.clk(clk), .nrst(nrst), .cmd(cmd), .stack_top(stack_top),
        .dacc(dacc), .fetch_addr(fetch_addr), .push_addr(push_addr), .push_en(push_en),
        .bank_sel(bank_sel), .rdata(rdata), .sfr_hit(sfr_hit), .sfr_addr(sfr_addr),
        .wo_regs(wo_regs));
    ppb_stack_model i_ppb_stack_model (.clk(clk), .nrst(nrst), .push_en(push_en),
        .push_addr(push_addr), .pop(cmd.op == PPB_OP_RET), .stack_top(stack_top));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs

    function automatic int gidx(input logic [5:0] a, input logic [1:0] b);
        return (a < GPR_BANKED_LO) ? int'(a) - 16 : 16 + int'(b) * 32 + int'(a[4:0]);
    endfunction : gidx

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic note(input int kind, input logic [31:0] exp);
        notes.push_back('{cyc + 1, kind, exp});
    endtask : note

    task automatic tally_and_finish();
        if (notes.size() != 0)
            bad_count++;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // driver: one operation per cycle, expectation noted at once
    // ------------------------------------------------------------
    task automatic drive(input ppb_op_t op, input logic [11:0] tgt, input logic [7:0] opnd,
                         input logic rd, input logic wr, input logic ind,
                         input logic [5:0] addr, input logic [7:0] wd);
        logic        pe;
        logic [11:0] pa;
        logic [5:0]  a;
        logic [11:0] opc;
        @(negedge clk);
        nrst = 1'b1;
        cmd  = '{op, tgt, opnd};
        dacc = '{rd, wr, ind, addr, wd};
        pe   = 1'b0;
        pa   = m_pc + 12'h001;
        opc  = m_pc;
        a    = ind ? m_fsr[5:0] : addr;
        case (op)
            PPB_OP_NONE: ;
            PPB_OP_JUMP: m_pc = {m_pch[3:2], tgt[9:0]};
            PPB_OP_CALL:
            begin
                pe   = 1'b1;
                m_pc = {m_pch[3:2], tgt[9:0]};
            end
            PPB_OP_FJUMP: m_pc = tgt;
            PPB_OP_FAR_CALL_INSTR:
            begin
                pe   = 1'b1;
                m_pc = tgt;
            end
            PPB_OP_RET: m_pc = m_stk.pop_back();
            PPB_OP_HWIRQ:
            begin
                pe   = 1'b1;
                pa   = m_pc;
                m_pc = PC_HW_IRQ_VEC;
            end
            PPB_OP_SWIRQ:
            begin
                pe   = 1'b1;
                m_pc = PC_SW_IRQ_VEC;
            end
            default:
            begin
                m_pc = m_pc + 12'h001;
                if (op == PPB_OP_PAGE)
                    m_pch[3:2] = opnd[1:0];
                if (op == PPB_OP_BANK)
                    m_fsr[7:6] = opnd[1:0];
                if (op == PPB_OP_OPT)
                    m_wo.opt = wd;
                if (op == PPB_OP_DIR && opnd == 8'h05)
                    m_wo.dir_a = wd;
                if (op == PPB_OP_DIR && opnd == 8'h06)
                    m_wo.dir_b = wd;
                if (op == PPB_OP_DIR && opnd == 8'h07)
                    m_wo.dir_c = wd;
            end
        endcase
        if (pe)
            m_stk.push_back(pa);
        if (rd)
            note(1, (a == ADDR_FSR) ? m_fsr : (a == ADDR_PC_HIGH_LATCH) ? m_pch :
                    (a == ADDR_PCL) ? opc[7:0] :
                    (a > SFR_LAST) ? m_mem[gidx(a, m_fsr[7:6])] : 8'h00);
        if (rd || wr)
            note(4, {(a <= SFR_LAST), a});
        if (wr && a == ADDR_FSR)
            m_fsr = wd;
        else if (wr && a == ADDR_PC_HIGH_LATCH)
            m_pch = {4'h0, wd[3:0]};
        else if (wr && a > SFR_LAST)
            m_mem[gidx(a, m_fsr[7:6])] = wd;
        note(0, {pe, pa, 7'h00, m_pc});
        note(2, m_fsr[7:6]);
        note(3, m_wo);
    endtask : drive

    task automatic op(input ppb_op_t o, input logic [11:0] tgt, input logic [7:0] opnd);
        drive(o, tgt, opnd, 1'b0, 1'b0, 1'b0, 6'h00, 8'h00);
    endtask : op

    task automatic acc(input logic rd, input logic ind, input logic [5:0] a, input logic [7:0] wd);
        drive(PPB_OP_NONE, 12'h000, 8'h00, rd, !rd, ind, a, wd);
    endtask : acc

    task automatic do_reset();
        repeat (3)
        begin
            @(negedge clk);
            nrst  = 1'b0;
            m_pc  = PC_RESET_VEC;
            m_pch = PCH_RESET;
            m_fsr = FSR_RESET;
            m_wo  = '{OPT_RESET, DIR_RESET, DIR_RESET, DIR_RESET};
            m_stk.delete();
            foreach (m_mem[i])
                m_mem[i] = 8'h00;
            note(0, {1'b0, 19'h0, PC_RESET_VEC});
            note(1, 8'h00);
            note(2, 2'b00);
            note(3, m_wo);
        end
    endtask : do_reset

    // ------------------------------------------------------------
    // monitor: oldest notes compared as results appear
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        #1;
        cyc++;
        while (notes.size() > 0 && notes[0].cyc <= cyc)
        begin
            nt = notes.pop_front();
            case (nt.kind)
                0:
                begin
                    check("fetch_addr", 32'(fetch_addr), 32'(nt.exp[11:0]));
                    check("push_en", 32'(push_en), 32'(nt.exp[31]));
                    if (nt.exp[31])
                        check("push_addr", 32'(push_addr), 32'(nt.exp[30:19]));
                end
                1: check("rdata", 32'(rdata), nt.exp);
                2: check("bank_sel", 32'(bank_sel), nt.exp);
                3: check("wo_regs", 32'(wo_regs), nt.exp);
                default:
                begin
                    check("sfr_hit", 32'(sfr_hit), 32'(nt.exp[6]));
                    if (nt.exp[6])
                        check("sfr_addr", 32'(sfr_addr), 32'(nt.exp[5:0]));
                end
            endcase
        end
    end

    always #4 clk = ~clk;

    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        nrst = 1'b0;
        cmd = '0;
        dacc = '0;
        rng = 32'd543;
        cyc = 0;
        do_reset();
        op(PPB_OP_NEXT, 12'h000, 8'h00);
        op(PPB_OP_PAGE, 12'h000, 8'h02);
        op(PPB_OP_JUMP, 12'hc5a, 8'h00);
        acc(1'b0, 1'b0, ADDR_PC_HIGH_LATCH, 8'hfc);
        acc(1'b1, 1'b0, ADDR_PC_HIGH_LATCH, 8'h00);
        op(PPB_OP_CALL, 12'h123, 8'h00);
        op(PPB_OP_NEXT, 12'h000, 8'h00);
        op(PPB_OP_RET, 12'h000, 8'h00);
        op(PPB_OP_FAR_CALL_INSTR, 12'h4e1, 8'h00);
        op(PPB_OP_FJUMP, 12'h9b7, 8'h00);
        op(PPB_OP_HWIRQ, 12'h000, 8'h00);
        op(PPB_OP_SWIRQ, 12'h000, 8'h00);
        op(PPB_OP_NEXT, 12'h000, 8'h00);
        repeat (3) op(PPB_OP_RET, 12'h000, 8'h00);
        for (int b = 0; b < 8; b++)
        begin
            rng = xs(rng);
            op(PPB_OP_BANK, 12'h000, 8'(b % 4));
            acc(b > 3, 1'b0, 6'h25, rng[7:0]);
            acc(b > 3, 1'b0, 6'h3f, rng[15:8]);
            acc(b > 3, 1'b0, 6'(16 + b % 4), rng[23:16]);
            acc(1'b0, 1'b0, ADDR_FSR, {2'(b), 6'h2a});
            acc(b > 3, 1'b1, 6'h00, rng[31:24]);
            acc(1'b1, 1'b0, 6'h2a, 8'h00);
            acc(1'b1, 1'b0, ADDR_FSR, 8'h00);
        end
        for (int a = 1; a < 16; a++)
            acc(1'b1, 1'b0, 6'(a), 8'h00);
        rng = xs(rng);
        drive(PPB_OP_OPT, 12'h000, 8'h00, 1'b0, 1'b0, 1'b0, 6'h00, rng[7:0] | 8'h80);
        acc(1'b0, 1'b0, ADDR_DIR_A, 8'h00);
        for (int d = 5; d < 9; d++)
            drive(PPB_OP_DIR, 12'h000, 8'(d), 1'b0, 1'b0, 1'b0, 6'h00, rng[15:8] + 8'(d));
        repeat (40)
        begin
            rng = xs(rng);
            op(rops[rng[2:0] % 5], rng[23:12], rng[31:24]);
        end
        do_reset();
        acc(1'b1, 1'b0, 6'h25, 8'h00);
        op(PPB_OP_NEXT, 12'h000, 8'h00);
        op(PPB_OP_NONE, 12'h000, 8'h00);
        repeat (3) @(negedge clk);
        tally_and_finish();
    end
endmodule : tb
